// *** rtl/timer_b_pkg.sv ***
// Package for the timer_b_unit: register offsets, field positions, modes.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package timer_b_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index).
   localparam logic [7:0] IDX_CONTROL_A = 8'h00;
   localparam logic [7:0] IDX_CONTROL_B = 8'h01;
   localparam logic [7:0] IDX_EVENT_CONTROL = 8'h04;
   localparam logic [7:0] IDX_INTERRUPT_ENABLE = 8'h05;
   localparam logic [7:0] IDX_INTERRUPT_FLAGS = 8'h06;
   localparam logic [7:0] IDX_STATUS = 8'h07;
   localparam logic [7:0] IDX_DEBUG_CONTROL = 8'h08;
   localparam logic [7:0] IDX_BYTE_LATCH = 8'h09;
   localparam logic [7:0] IDX_COUNT_LO = 8'h0A;
   localparam logic [7:0] IDX_COUNT_HI = 8'h0B;
   localparam logic [7:0] IDX_CMP_LO = 8'h0C;
   localparam logic [7:0] IDX_CMP_HI = 8'h0D;
   // ==========================================================
   // Field positions.
   localparam int BIT_ENABLE = 0;
   localparam int BIT_CLOCK_SOURCE_SELECT_LO = 1;
   localparam int BIT_RESTART_A = 4;
   localparam int BIT_STANDBY_RUN = 6;
   localparam int BIT_OUT_EN = 4;
   localparam int BIT_OUT_INIT = 5;
   localparam int BIT_OUT_OUTPUT_UPDATE_A = 6;
   localparam int BIT_EV_EN = 0;
   localparam int BIT_EDGE = 4;
   localparam int BIT_FILTER = 6;
   // Reset values and write masks.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0] MASK_CONTROL_A = 8'h57;
   localparam logic [7:0] MASK_CONTROL_B = 8'h77;
   localparam logic [7:0] MASK_EVENT_CONTROL = 8'h51;
   localparam logic [7:0] MASK_BIT0 = 8'h01;
   localparam logic [15:0] TOP_VALUE = 16'hFFFF;
   localparam int FILTER_DEPTH = 4;
   // ==========================================================
   // Clock sources and counting modes.
   localparam logic [1:0] PERIPHERAL_CLOCK = 2'h0;
   localparam logic [1:0] PERIPHERAL_CLOCK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_TIMER_A = 2'h2;
   typedef enum logic [2:0] {
      MODE_PERIODIC, MODE_TIMEOUT, MODE_CAPTURE, MODE_FREQ,
      MODE_PULSE, MODE_FREQ_PULSE, MODE_SINGLE, MODE_PWM8
   } count_mode_type;
   // AHB transfer type.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : timer_b_pkg

// *** rtl/timer_b_unit.sv ***
// Timer B capture/compare unit with an AHB-Lite register slave.
// Assumes event_in and timer-A signals come from another domain or pins.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module timer_b_unit
   import timer_b_pkg::*;
(
   input wire logic clk_sys, // System clock, 20 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic hsel, // AHB slave select.
   input wire logic [31:0] haddr, // AHB address.
   input wire logic [1:0] htrans, // AHB transfer type.
   input wire logic hwrite, // AHB write strobe.
   input wire logic [2:0] hsize, // AHB transfer size.
   input wire logic [31:0] hwdata, // AHB write data.
   input wire logic hready, // AHB bus ready.
   output logic [31:0] hrdata, // AHB read data.
   output logic hreadyout, // AHB slave ready.
   output logic hresp, // AHB response, always OKAY.
   input wire logic event_in, // Event input from the routing fabric.
   input wire logic timer_a_tick, // Timer A clock enable pulse level.
   input wire logic timer_a_restart, // Timer A restart indication.
   input wire logic standby_mode, // Device is in standby sleep.
   input wire logic debug_halt, // CPU halted in break debug mode.
   output logic compare_out, // Compare/capture output.
   output logic capture_irq // Interrupt request.
);
   // ==========================================================
   // Register state.
   logic [7:0] control_a_reg, control_b_reg, event_control_reg;
   logic [7:0] interrupt_enable_reg, debug_control_reg, byte_latch_reg;
   logic [15:0] counter_value_reg, compare_capture_reg;
   logic flag_reg, running_reg, out_reg, half_reg, second_reg;
   logic wr_pend_reg, rd_pend_reg;
   logic [7:0] idx_reg;
   logic [FILTER_DEPTH-1:0] hist_reg;
   logic [1:0] ev_sync_reg, ta_sync_reg, tr_sync_reg;
   logic ev_clean_reg, ev_prev_reg, tr_prev_reg;
   logic [7:0] idx;
   logic wr_go, rd_go, tick, active, ev_en, edge_sel, top_hit;
   logic rise, fall, ev_go, ev_start, ev_end, ta_restart;
   count_mode_type mode;
   assign mode = count_mode_type'(control_b_reg[2:0]);
   assign edge_sel = event_control_reg[BIT_EDGE];
   assign idx = haddr[9:2];
   // ==========================================================
   // AHB address phase capture; always zero wait states.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         idx_reg <= RESET_BYTE;
      end else begin
         wr_pend_reg <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
         rd_pend_reg <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
         if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            idx_reg <= idx;
         end
      end
   end
   assign wr_go = wr_pend_reg;
   // Read data is registered at the address phase edge.
   assign rd_go = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (rd_go) begin
         unique case (idx)
            IDX_CONTROL_A: hrdata <= {24'h000000, control_a_reg};
            IDX_CONTROL_B: hrdata <= {24'h000000, control_b_reg};
            IDX_EVENT_CONTROL: hrdata <= {24'h000000, event_control_reg};
            IDX_INTERRUPT_ENABLE:
               hrdata <= {24'h000000, interrupt_enable_reg};
            IDX_INTERRUPT_FLAGS: hrdata <= {31'h00000000, flag_reg};
            IDX_STATUS: hrdata <= {31'h00000000, running_reg};
            IDX_DEBUG_CONTROL: hrdata <= {24'h000000, debug_control_reg};
            IDX_BYTE_LATCH: hrdata <= {24'h000000, byte_latch_reg};
            IDX_COUNT_LO: hrdata <= {24'h000000, counter_value_reg[7:0]};
            IDX_COUNT_HI: hrdata <= {24'h000000, byte_latch_reg};
            IDX_CMP_LO: hrdata <= {24'h000000, compare_capture_reg[7:0]};
            IDX_CMP_HI: hrdata <= {24'h000000, byte_latch_reg};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end
   // ==========================================================
   // Plain control registers.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         control_a_reg <= RESET_BYTE;
         control_b_reg <= RESET_BYTE;
         event_control_reg <= RESET_BYTE;
         interrupt_enable_reg <= RESET_BYTE;
         debug_control_reg <= RESET_BYTE;
      end else if (wr_go) begin
         if (idx_reg == IDX_CONTROL_A)
            control_a_reg <= hwdata[7:0] & MASK_CONTROL_A;
         if (idx_reg == IDX_CONTROL_B)
            control_b_reg <= hwdata[7:0] & MASK_CONTROL_B;
         if (idx_reg == IDX_EVENT_CONTROL)
            event_control_reg <= hwdata[7:0] & MASK_EVENT_CONTROL;
         if (idx_reg == IDX_INTERRUPT_ENABLE)
            interrupt_enable_reg <= hwdata[7:0] & MASK_BIT0;
         if (idx_reg == IDX_DEBUG_CONTROL)
            debug_control_reg <= hwdata[7:0] & MASK_BIT0;
      end
   end
   // Shared byte latch: low-byte reads load the high half, writes stage it.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         byte_latch_reg <= RESET_BYTE;
      end else if (wr_go && (idx_reg == IDX_BYTE_LATCH
                  || idx_reg == IDX_COUNT_LO || idx_reg == IDX_CMP_LO)) begin
         byte_latch_reg <= hwdata[7:0];
      end else if (rd_go && idx == IDX_COUNT_LO) begin
         byte_latch_reg <= counter_value_reg[15:8];
      end else if (rd_go && idx == IDX_CMP_LO) begin
         byte_latch_reg <= compare_capture_reg[15:8];
      end
   end
   // ==========================================================
   // Event and timer A inputs pass two flip-flops first.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ev_sync_reg <= 2'h0;
         ta_sync_reg <= 2'h0;
         tr_sync_reg <= 2'h0;
      end else begin
         ev_sync_reg <= {ev_sync_reg[0], event_in};
         ta_sync_reg <= {ta_sync_reg[0], timer_a_tick};
         tr_sync_reg <= {tr_sync_reg[0], timer_a_restart};
      end
   end
   // Noise canceller: the level passes only after four equal samples.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hist_reg <= '0;
         ev_clean_reg <= 1'b0;
         ev_prev_reg <= 1'b0;
         tr_prev_reg <= 1'b0;
      end else begin
         hist_reg <= {hist_reg[FILTER_DEPTH-2:0], ev_sync_reg[1]};
         if (!event_control_reg[BIT_FILTER]) begin
            ev_clean_reg <= ev_sync_reg[1];
         end else if (&hist_reg || ~|hist_reg) begin
            ev_clean_reg <= hist_reg[0];
         end
         ev_prev_reg <= ev_clean_reg;
         tr_prev_reg <= tr_sync_reg[1];
      end
   end
   // ==========================================================
   // Counting permission and clock selection.
   always_comb begin
      active = control_a_reg[BIT_ENABLE];
      if (standby_mode && !control_a_reg[BIT_STANDBY_RUN]
          && control_a_reg[2:1] != CLK_TIMER_A) begin
         active = 1'b0;
      end
      if (debug_halt && !debug_control_reg[0]) begin
         active = 1'b0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         half_reg <= 1'b0;
      end else begin
         half_reg <= ~half_reg;
      end
   end
   always_comb begin
      unique case (control_a_reg[2:1])
         PERIPHERAL_CLOCK: tick = 1'b1;
         PERIPHERAL_CLOCK_DIV2: tick = half_reg;
         CLK_TIMER_A: tick = ta_sync_reg[1];
         default: tick = 1'b0;
      endcase
   end
   assign ev_en = event_control_reg[BIT_EV_EN] && active;
   assign rise = ev_en && ev_clean_reg && !ev_prev_reg;
   assign fall = ev_en && !ev_clean_reg && ev_prev_reg;
   assign ev_start = edge_sel ? fall : rise;
   assign ev_end = edge_sel ? rise : fall;
   assign ev_go = (mode == MODE_SINGLE && edge_sel) ? (rise || fall)
                  : ev_start;
   assign ta_restart = control_a_reg[BIT_RESTART_A] && tr_sync_reg[1]
                       && !tr_prev_reg;
   assign top_hit = (mode == MODE_PWM8)
                    ? counter_value_reg[7:0] == compare_capture_reg[15:8]
                    : counter_value_reg == compare_capture_reg;
   // ==========================================================
   // Counter, capture register and running state per mode.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         counter_value_reg <= RESET_WORD;
         compare_capture_reg <= RESET_WORD;
         running_reg <= 1'b0;
         second_reg <= 1'b0;
      end else if (wr_go && idx_reg == IDX_COUNT_HI) begin
         counter_value_reg <= {hwdata[7:0], byte_latch_reg};
      end else begin
         if (wr_go && idx_reg == IDX_CMP_HI)
            compare_capture_reg <= {hwdata[7:0], byte_latch_reg};
         if (!active) begin
            running_reg <= 1'b0;
         end else if (ta_restart) begin
            counter_value_reg <= RESET_WORD;
         end else begin
            unique case (mode)
               MODE_PERIODIC, MODE_PWM8: begin
                  running_reg <= 1'b1;
                  if (tick) begin
                     if (mode == MODE_PWM8
                         && counter_value_reg[7:0] >= compare_capture_reg[7:0])
                        counter_value_reg <= RESET_WORD;
                     else if (mode == MODE_PERIODIC && top_hit)
                        counter_value_reg <= RESET_WORD;
                     else
                        counter_value_reg <= counter_value_reg + 16'h0001;
                  end
               end
               MODE_TIMEOUT: begin
                  if (ev_start) begin
                     running_reg <= 1'b1;
                     counter_value_reg <= RESET_WORD;
                  end else if (ev_end) begin
                     running_reg <= 1'b0;
                  end else if (running_reg && tick && !top_hit) begin
                     counter_value_reg <= counter_value_reg + 16'h0001;
                  end
               end
               MODE_CAPTURE, MODE_FREQ, MODE_PULSE: begin
                  running_reg <= 1'b1;
                  if ((mode == MODE_CAPTURE && ev_start)
                      || (mode == MODE_FREQ && ev_start)
                      || (mode == MODE_PULSE && ev_end))
                     compare_capture_reg <= counter_value_reg;
                  if ((mode == MODE_FREQ || mode == MODE_PULSE) && ev_start)
                     counter_value_reg <= RESET_WORD;
                  else if (tick)
                     counter_value_reg <= counter_value_reg + 16'h0001;
               end
               MODE_FREQ_PULSE: begin
                  if (ev_start && !running_reg) begin
                     running_reg <= 1'b1;
                     second_reg <= 1'b0;
                     counter_value_reg <= RESET_WORD;
                  end else if (ev_start) begin
                     running_reg <= 1'b0;
                  end else begin
                     if (ev_end && running_reg && !second_reg) begin
                        compare_capture_reg <= counter_value_reg;
                        second_reg <= 1'b1;
                     end
                     if (running_reg && tick)
                        counter_value_reg <= counter_value_reg + 16'h0001;
                  end
               end
               MODE_SINGLE: begin
                  if (ev_go && !running_reg) begin
                     running_reg <= 1'b1;
                     counter_value_reg <= RESET_WORD;
                  end else if (running_reg && tick) begin
                     if (top_hit)
                        running_reg <= 1'b0;
                     else
                        counter_value_reg <= counter_value_reg + 16'h0001;
                  end
               end
            endcase
         end
         // A mode write drops any run left over from the previous mode.
         if (wr_go && idx_reg == IDX_CONTROL_B) begin
            running_reg <= 1'b0;
            second_reg <= 1'b0;
         end
      end
   end
   // ==========================================================
   // Interrupt flag: events set it, write-one or capture read clear it.
   logic irq_set, irq_clr;
   always_comb begin
      irq_set = 1'b0;
      if (active) begin
         unique case (mode)
            MODE_PERIODIC, MODE_TIMEOUT, MODE_SINGLE:
               irq_set = tick && top_hit && running_reg;
            MODE_CAPTURE, MODE_FREQ: irq_set = ev_start;
            MODE_PULSE: irq_set = ev_end;
            MODE_FREQ_PULSE: irq_set = ev_start && running_reg;
            MODE_PWM8: irq_set = tick && top_hit;
         endcase
      end
   end
   assign irq_clr = (wr_go && idx_reg == IDX_INTERRUPT_FLAGS && hwdata[0])
                    || (rd_go && idx == IDX_CMP_LO
                        && mode >= MODE_CAPTURE && mode <= MODE_FREQ_PULSE);
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
      end else if (irq_set) begin
         flag_reg <= 1'b1; // Set wins over clear.
      end else if (irq_clr) begin
         flag_reg <= 1'b0;
      end
   end
   assign capture_irq = flag_reg && interrupt_enable_reg[0];
   // ==========================================================
   // Output level per mode.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         out_reg <= 1'b0;
      end else if (!control_b_reg[BIT_OUT_EN]) begin
         out_reg <= 1'b0;
      end else if (mode == MODE_SINGLE) begin
         if (control_b_reg[BIT_OUT_OUTPUT_UPDATE_A] && ev_go)
            out_reg <= 1'b1;
         else
            out_reg <= running_reg;
      end else if (mode == MODE_PWM8) begin
         out_reg <= active
                    && counter_value_reg[7:0] < compare_capture_reg[15:8];
      end else begin
         out_reg <= control_b_reg[BIT_OUT_INIT];
      end
   end
   assign compare_out = out_reg;
   // ==========================================================
   // Checks.
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      capture_irq == (flag_reg && interrupt_enable_reg[0]))
      else $error("irq not flag and enable");
   a_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      irq_set |=> flag_reg)
      else $error("flag not set after event");
   a_out_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !control_b_reg[BIT_OUT_EN] |=> !compare_out)
      else $error("output not forced low");
   a_disable_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !active |=> !running_reg)
      else $error("running while disabled");
   a_freq_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mode == MODE_FREQ && ev_start && !ta_restart && !wr_go)
      |=> compare_capture_reg == $past(counter_value_reg)
          && counter_value_reg == RESET_WORD)
      else $error("frequency capture wrong");
   a_timeout_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mode == MODE_TIMEOUT && active && ev_end && !ev_start && !ta_restart)
      |=> !running_reg)
      else $error("timeout stop missed");
   a_init_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (control_b_reg[BIT_OUT_EN] && mode == MODE_PERIODIC)
      |=> compare_out == $past(control_b_reg[BIT_OUT_INIT]))
      else $error("initial level wrong");
   a_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ta_restart && active && !wr_go) |=> counter_value_reg == RESET_WORD)
      else $error("no restart with timer a");
   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n)
      capture_irq);
   c_single: cover property (@(posedge clk_sys) disable iff (!rst_n)
      mode == MODE_SINGLE && compare_out);
   c_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n)
      mode == MODE_PULSE && ev_end);
endmodule : timer_b_unit

// *** dv/timer_a_model.sv ***
// Partner model: event routing fabric and companion timer A.
// Assumes the bench sets request levels just after a rising edge.
`timescale 1ns/1ps
module timer_a_model (
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic ev_level, // Event level wanted by the bench.
   input wire logic restart_req, // Restart wanted by the bench.
   output logic event_in, // Event line into the timer.
   output logic timer_a_tick, // Timer A count enable.
   output logic timer_a_restart // Timer A restart level.
);
   logic [1:0] div_reg;
   // ==========================================================
   // Prescaler: one tick in four clocks; the fabric adds one flop.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_reg <= 2'h0;
         event_in <= 1'b0;
         timer_a_restart <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         event_in <= ev_level;
         timer_a_restart <= restart_req;
      end
   end
   assign timer_a_tick = (div_reg == 2'h3);
endmodule : timer_a_model

// *** dv/test_timer_b_unit.sv ***
// Bench for timer_b_unit: AHB-Lite tasks, event stimulus, self checks.
// Assumes a zero-wait slave and the timer_a_model partner.
`timescale 1ns/1ps
module test_timer_b_unit;
   import timer_b_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, compare_out, capture_irq, event_in, tick, rsta;
   logic ev = 1'b0, rreq = 1'b0, stby = 1'b0, halt = 1'b0;
   logic [7:0] d;
   int num_errors = 0, check_count = 0;
   logic [7:0] ix[10] = '{IDX_CONTROL_A, IDX_CONTROL_B, IDX_EVENT_CONTROL,
      IDX_INTERRUPT_ENABLE, IDX_INTERRUPT_FLAGS, IDX_STATUS,
      IDX_DEBUG_CONTROL, IDX_BYTE_LATCH, IDX_COUNT_LO, 8'h02};
   // ==========================================================
   // Clock of 50 ns period.
   always #25 clk_sys = ~clk_sys;
   timer_b_unit i_dut (.clk_sys, .rst_n, .hsel(1'b1), .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .event_in, .timer_a_tick(tick),
      .timer_a_restart(rsta), .standby_mode(stby), .debug_halt(halt),
      .compare_out, .capture_irq);
   timer_a_model i_far (.clk_sys, .rst_n, .ev_level(ev),
      .restart_req(rreq), .event_in, .timer_a_tick(tick),
      .timer_a_restart(rsta));
   // ==========================================================
   // Prints the verdict and ends the run.
   task automatic complete_run;
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // Compares one value and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Waits for hready at a rising edge, under a bound.
   task automatic edge_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         complete_run;
      end
   endtask : edge_rdy
   // One single word transfer; read data is taken at the closing edge.
   task automatic bus(input logic w, input logic [7:0] ri,
         input logic [31:0] wd);
      @(posedge clk_sys);
      htrans <= HTRANS_NONSEQ;
      haddr <= {22'h0, ri, 2'h0};
      hwrite <= w;
      edge_rdy;
      htrans <= 2'h0;
      hwdata <= wd;
      edge_rdy;
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] ri, input logic [31:0] wd);
      bus(1'b1, ri, wd);
   endtask : wr
   task automatic rc(input logic [7:0] ri, input logic [31:0] exp);
      bus(1'b0, ri, 32'h0);
      chk(rd, exp);
   endtask : rc
   // Measures the count advance over a fixed gap of 23 clocks.
   task automatic rate(input logic [7:0] ca, input logic s, h,
         input logic [7:0] dr, input int lo, hi);
      wr(IDX_CONTROL_A, {24'h0, ca});
      wr(IDX_DEBUG_CONTROL, {24'h0, dr});
      stby <= s;
      halt <= h;
      bus(1'b0, IDX_COUNT_LO, 32'h0);
      d = rd[7:0];
      repeat (20) @(posedge clk_sys);
      bus(1'b0, IDX_COUNT_LO, 32'h0);
      d = rd[7:0] - d;
      chk(d >= lo && d <= hi, 1);
      stby <= 1'b0;
      halt <= 1'b0;
   endtask : rate
   // Three event edges: start, then 12 clocks, then 8 clocks.
   task automatic meas(input logic [2:0] m, input logic e, input int x);
      wr(IDX_EVENT_CONTROL, 32'h0);
      ev <= e;
      wr(IDX_CONTROL_B, {29'h0, m});
      wr(IDX_EVENT_CONTROL, {27'h0, e, 4'h1});
      wr(IDX_INTERRUPT_FLAGS, 32'h1);
      ev <= !e;
      repeat (12) @(posedge clk_sys);
      ev <= e;
      repeat (8) @(posedge clk_sys);
      ev <= !e;
      repeat (12) @(posedge clk_sys);
      chk(capture_irq, 1);
      bus(1'b0, IDX_CMP_LO, 32'h0);
      chk(rd[15:0] >= x - 2 && rd[15:0] <= x + 2, 1);
      rc(IDX_INTERRUPT_FLAGS, 32'h0);
   endtask : meas
   // A high pulse of n clocks, then time for the event path to settle.
   task automatic pulse(input int n);
      ev <= 1'b1;
      repeat (n) @(posedge clk_sys);
      ev <= 1'b0;
      repeat (15) @(posedge clk_sys);
   endtask : pulse
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (ix[i]) rc(ix[i], 32'h0);
      wr(IDX_CONTROL_A, 32'hFF);
      rc(IDX_CONTROL_A, {24'h0, MASK_CONTROL_A});
      wr(8'h02, 32'hFF);
      rc(8'h02, 32'h0);
      wr(IDX_BYTE_LATCH, 32'hA5);
      rc(IDX_BYTE_LATCH, 32'hA5);
      wr(IDX_CMP_LO, 32'h34);
      wr(IDX_CMP_HI, 32'h12);
      rc(IDX_CMP_LO, 32'h34);
      rc(IDX_CMP_HI, 32'h12);
      wr(IDX_CMP_LO, 32'hFF);
      wr(IDX_CMP_HI, 32'hFF);
      wr(IDX_CONTROL_B, 32'h20);
      repeat (3) @(posedge clk_sys);
      chk(compare_out, 0);
      wr(IDX_CONTROL_B, 32'h30);
      repeat (3) @(posedge clk_sys);
      chk(compare_out, 1);
      wr(IDX_CONTROL_B, 32'h10);
      repeat (3) @(posedge clk_sys);
      chk(compare_out, 0);
      rate(8'h01, 0, 0, 8'h0, 19, 25);
      rc(IDX_STATUS, 32'h1);
      rate(8'h03, 0, 0, 8'h0, 9, 13);
      rate(8'h05, 0, 0, 8'h0, 4, 7);
      rate(8'h05, 1, 0, 8'h0, 4, 7);
      rate(8'h01, 1, 0, 8'h0, 0, 0);
      rate(8'h41, 1, 0, 8'h0, 19, 25);
      rate(8'h01, 0, 1, 8'h0, 0, 0);
      rate(8'h01, 0, 1, 8'h1, 19, 25);
      rate(8'h00, 0, 0, 8'h0, 0, 0);
      rc(IDX_STATUS, 32'h0);
      wr(IDX_CONTROL_A, 32'h11);
      repeat (30) @(posedge clk_sys);
      rreq <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rreq <= 1'b0;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, IDX_COUNT_LO, 32'h0);
      chk(rd[15:0] < 10, 1);
      wr(IDX_CONTROL_A, 32'h01);
      wr(IDX_INTERRUPT_ENABLE, 32'h1);
      for (int m = 3; m <= 5; m++) begin
         for (int e = 0; e <= 1; e++) begin
            meas(3'(m), 1'(e), (m == 3) ? 20 : 12);
         end
      end
      wr(IDX_CONTROL_B, 32'h3);
      wr(IDX_EVENT_CONTROL, 32'h41);
      wr(IDX_INTERRUPT_FLAGS, 32'h1);
      pulse(2);
      rc(IDX_INTERRUPT_FLAGS, 32'h0);
      wr(IDX_EVENT_CONTROL, 32'h0);
      pulse(10);
      pulse(10);
      rc(IDX_INTERRUPT_FLAGS, 32'h0);
      chk(capture_irq, 0);
      chk(hresp, 0);
      // Timeout check: a ten clock pulse starts and then stops the count.
      wr(IDX_CONTROL_B, 32'h1);
      wr(IDX_EVENT_CONTROL, 32'h1);
      pulse(10);
      rc(IDX_COUNT_LO, 32'h9);
      rc(IDX_STATUS, 32'h0);
      // Single shot with top five: output high while running, then low.
      wr(IDX_CMP_LO, 32'h5);
      wr(IDX_CMP_HI, 32'h0);
      wr(IDX_CONTROL_B, 32'h56);
      ev <= 1'b1;
      repeat (7) @(posedge clk_sys);
      chk(compare_out, 1);
      ev <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk(compare_out, 0);
      chk(capture_irq, 1);
      wr(IDX_INTERRUPT_FLAGS, 32'h1);
      rc(IDX_INTERRUPT_FLAGS, 32'h0);
      complete_run;
   end
endmodule : test_timer_b_unit
